// ===== inc/hwltc_pkg.sv
// Constants, types and register map of the external line trigger exposure controller.
// What this block does
// [RL1] Switch on and a camera control input selected: that input becomes the line trigger.
// [RL2] Edge select chooses whether rising or falling trigger edges are active.
// [RL3] An active edge while waiting for a trigger starts a line acquisition.
// [RL4] An accepted trigger clears the waiting-for-trigger status.
// [RL5] Waiting status returns by itself once a new trigger can be accepted.
// [RL6] Active edges arriving while not waiting are discarded as overtriggers, no line started.
// [RL7] Exactly one line is acquired per accepted trigger.
// [RL8] The trigger source should not exceed the maximum allowed line rate.
// [RL9] Two exposure styles exist: fixed length and trigger pulse width.
// [RL10] Fixed length exposure uses the exposure length, limited to 2.0 to 10000 us.
// [RL11] Fixed length exposure starts on the selected active edge.
// [RL12] Edges during a running fixed exposure neither restart nor extend it.
// [RL13] Pulse width, rising activation: expose from rising edge to next falling edge.
// [RL14] Pulse width, falling activation: expose from falling edge to next rising edge.
// [RL15] Trigger pulse lasts at least 2.0 us; no upper exposure limit.
// [RL16] Pulse width style uses the overlap exposure limit to raise trigger ready.
// [RL17] Controller sets the overlap limit to its shortest intended exposure.
// [RL18] Controller disables internal line period generation for external triggering.
// [RL19] The frame grabber drives trigger pulses onto the selected input.
// [RL20] Exposure length counts whole time base ticks of 100 ns.
// [RL21] Ready status reads 1 when a trigger can be accepted, else 0.
// [RL22] Start delay 1.5 us, end delay 1.2 us, each plus debouncer setting.
package hwltc_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 100;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXP_MIN_NS = 2000;
   localparam int EXP_MAX_NS = 10000000;
   localparam int START_DLY_NS = 1500;
   localparam int END_DLY_NS = 1200;
   localparam int EXP_MIN_TICKS = (EXP_MIN_NS + TICK_NS - 1) / TICK_NS;
   localparam int EXP_MAX_TICKS = EXP_MAX_NS / TICK_NS;
   localparam int START_TICKS = (START_DLY_NS + TICK_NS - 1) / TICK_NS;
   localparam int END_TICKS = (END_DLY_NS + TICK_NS - 1) / TICK_NS;
   localparam int DIV_W = 3;
   localparam int CNT_W = 24;
   localparam int EXP_W = 17;
   localparam int DEB_W = 10;
   localparam int CFG_W = 6;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EXP = 8'h04;
   localparam logic [7:0] ADDR_OVL = 8'h08;
   localparam logic [7:0] ADDR_DEB = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_LINES = 8'h14;
   localparam logic [CFG_W-1:0] CTRL_RST = 6'h00;
   localparam logic [EXP_W-1:0] EXP_RST = 17'h00bb8;
   localparam logic [EXP_W-1:0] OVL_RST = 17'h00014;
   localparam logic [DEB_W-1:0] DEB_RST = 10'h000;
   localparam int STAT_WAIT_BIT = 0;
   localparam int STAT_EXP_BIT = 1;
   localparam int STAT_OVT_BIT = 2;
   localparam int STAT_SHORT_BIT = 3;

   // Field order from bit 0 upward: switch, input select (2), edge, style, line period enable.
   typedef struct packed {
      logic lpen;
      logic style_width;
      logic edge_fall;
      logic [1:0] sel;
      logic sw;
   } hwltc_cfg_t;

   typedef struct packed {
      logic exposing;
      logic ready;
      logic line_start;
      logic overtrig;
   } hwltc_stat_t;

   typedef enum logic [1:0] {
      ST_WAIT,
      ST_TIMED,
      ST_WIDTH,
      ST_TAIL
   } hwltc_state_t;
endpackage

// ===== rtl/hwltc_edge.sv
// Trigger input selector and edge detector.
`timescale 1ns/1ps
module hwltc_edge (
   input wire logic pclk,          // System clock.
   input wire logic presetn,       // Asynchronous reset, active low.
   input wire logic [3:0] cc_in,   // Camera control inputs.
   input wire logic [1:0] sel,     // Selected input.
   output logic rise,              // Rising edge pulse.
   output logic fall               // Falling edge pulse.
);
   logic [1:0] sel_r;
   logic prev_r;
   logic rise_r;
   logic fall_r;
   wire cur = cc_in[sel];
   // A change of selection must not look like an edge.
   wire sel_same = (sel == sel_r);

   // [RL1] Selected input use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= 2'h0;
         prev_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         sel_r <= sel;
         prev_r <= cur;
         rise_r <= sel_same & cur & ~prev_r;
         fall_r <= sel_same & ~cur & prev_r;
      end
   end

   assign rise = rise_r;
   assign fall = fall_r;
endmodule // hwltc_edge

// ===== rtl/hwltc_top.sv
// External line trigger exposure controller with APB register access.
`timescale 1ns/1ps
module hwltc_top #(
   parameter int EXP_MAX_TICKS = hwltc_pkg::EXP_MAX_TICKS
) (
   input wire logic pclk,                    // 50 MHz clock.
   input wire logic presetn,                 // Asynchronous reset, active low.
   input wire logic [7:0] paddr,             // APB address.
   input wire logic psel,                    // APB select.
   input wire logic penable,                 // APB enable.
   input wire logic pwrite,                  // APB direction.
   input wire logic [31:0] pwdata,           // APB write data.
   input wire logic [3:0] pstrb,             // APB byte strobes.
   output logic [31:0] prdata,               // APB read data.
   output logic pready,                      // APB ready.
   output logic pslverr,                     // APB error for unmapped address.
   input wire logic [3:0] cc_in,             // Camera control inputs.
   output hwltc_pkg::hwltc_stat_t line_status // Exposure and trigger status.
);
   localparam logic [hwltc_pkg::EXP_W-1:0] EXP_MIN = hwltc_pkg::EXP_W'(hwltc_pkg::EXP_MIN_TICKS);
   localparam logic [hwltc_pkg::EXP_W-1:0] EXP_MAX = hwltc_pkg::EXP_W'(EXP_MAX_TICKS);
   localparam logic [hwltc_pkg::DIV_W-1:0] DIV_LAST = hwltc_pkg::DIV_W'(hwltc_pkg::TICK_CYC - 1);
   localparam logic [hwltc_pkg::CNT_W-1:0] START_T = hwltc_pkg::CNT_W'(hwltc_pkg::START_TICKS);
   localparam logic [hwltc_pkg::CNT_W-1:0] END_T = hwltc_pkg::CNT_W'(hwltc_pkg::END_TICKS);
   localparam logic [hwltc_pkg::CNT_W-1:0] MIN_T = hwltc_pkg::CNT_W'(hwltc_pkg::EXP_MIN_TICKS);

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [hwltc_pkg::CNT_W-1:0] sat_inc(input logic [hwltc_pkg::CNT_W-1:0] v);
      return (&v) ? v : v + 24'h000001;
   endfunction

   hwltc_pkg::hwltc_cfg_t cfg_r;
   logic [hwltc_pkg::EXP_W-1:0] exp_r;
   logic [hwltc_pkg::EXP_W-1:0] ovl_r;
   logic [hwltc_pkg::DEB_W-1:0] deb_r;
   logic ovt_r;
   logic short_r;
   logic [31:0] lines_r;
   logic [31:0] prdata_r;
   hwltc_pkg::hwltc_state_t state_r;
   hwltc_pkg::hwltc_state_t state_nxt;
   logic [hwltc_pkg::DIV_W-1:0] tdiv_r;
   logic [hwltc_pkg::DIV_W-1:0] tdiv_nxt;
   logic [hwltc_pkg::CNT_W-1:0] t_cnt_r;
   logic [hwltc_pkg::CNT_W-1:0] t_cnt_nxt;
   logic [hwltc_pkg::CNT_W-1:0] e_cnt_r;
   logic [hwltc_pkg::CNT_W-1:0] e_cnt_nxt;
   logic exp_on_r;
   logic exp_nxt;
   logic line_start_r;
   logic ovt_pulse_r;
   logic rise;
   logic fall;

   hwltc_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .cc_in(cc_in),
      .sel(cfg_r.sel),
      .rise(rise),
      .fall(fall)
   );

   // Bus decode.
   wire setup_cyc = psel & ~penable;
   wire wr_en = psel & penable & pwrite;
   wire hit_ctrl = (paddr == hwltc_pkg::ADDR_CTRL);
   wire hit_exp = (paddr == hwltc_pkg::ADDR_EXP);
   wire hit_ovl = (paddr == hwltc_pkg::ADDR_OVL);
   wire hit_deb = (paddr == hwltc_pkg::ADDR_DEB);
   wire hit_stat = (paddr == hwltc_pkg::ADDR_STAT);
   wire hit_lines = (paddr == hwltc_pkg::ADDR_LINES);
   wire hit_any = hit_ctrl | hit_exp | hit_ovl | hit_deb | hit_stat | hit_lines;
   wire [31:0] wm_ctrl = wmerge({26'h0, cfg_r}, pwdata, pstrb);
   wire [31:0] wm_exp = wmerge({15'h0, exp_r}, pwdata, pstrb);
   wire [31:0] wm_ovl = wmerge({15'h0, ovl_r}, pwdata, pstrb);
   wire [31:0] wm_deb = wmerge({22'h0, deb_r}, pwdata, pstrb);
   wire [31:0] wm_stat = wmerge(32'h0, pwdata, pstrb);
   wire clr_ovt = wr_en & hit_stat & wm_stat[hwltc_pkg::STAT_OVT_BIT];
   wire clr_short = wr_en & hit_stat & wm_stat[hwltc_pkg::STAT_SHORT_BIT];

   // [RL10] Exposure length clamp.
   wire [hwltc_pkg::EXP_W-1:0] exp_eff = (exp_r < EXP_MIN) ? EXP_MIN :
                                         (exp_r > EXP_MAX) ? EXP_MAX : exp_r;
   // [RL22] Start and end delays.
   wire [hwltc_pkg::CNT_W-1:0] start_dly = START_T + {14'h0, deb_r};
   wire [hwltc_pkg::CNT_W-1:0] end_dly = END_T + {14'h0, deb_r};
   // [RL20] Exposure in ticks.
   wire [hwltc_pkg::CNT_W-1:0] timed_end = {7'h0, exp_eff} + end_dly;

   // [RL1] Trigger source enable.
   wire ext_mode = cfg_r.sw & ~cfg_r.lpen;
   // [RL2] Active edge choice.
   wire act_edge = cfg_r.edge_fall ? fall : rise;
   // [RL13] [RL14] Opposite edge ends pulse.
   wire inact_edge = cfg_r.edge_fall ? rise : fall;
   // [RL16] Overlap limit reached.
   wire ovl_ok = (t_cnt_r >= {7'h0, ovl_r});
   // [RL5] Waiting status returns.
   wire ready_int = (state_r == hwltc_pkg::ST_WAIT) |
                    ((state_r == hwltc_pkg::ST_TAIL) & ovl_ok);
   wire ready = ext_mode & ready_int;
   // [RL3] Trigger accepted.
   wire accept = ready & act_edge;
   // [RL6] Overtrigger detected.
   wire ovt_evt = ext_mode & act_edge & ~ready_int;
   wire tick_en = (tdiv_r == DIV_LAST);
   wire tail_go = (state_r == hwltc_pkg::ST_WIDTH) & inact_edge;
   wire short_evt = tail_go & (t_cnt_nxt < MIN_T);

   // Tick divider restarts at each timing origin so delays are cycle exact.
   assign tdiv_nxt = (accept | tail_go | tick_en) ? 3'h0 : tdiv_r + 3'h1;
   assign t_cnt_nxt = accept ? 24'h000000 :
                      (tick_en & (state_r != hwltc_pkg::ST_WAIT)) ? sat_inc(t_cnt_r) : t_cnt_r;
   assign e_cnt_nxt = tail_go ? 24'h000000 :
                      (tick_en & (state_r == hwltc_pkg::ST_TAIL)) ? sat_inc(e_cnt_r) : e_cnt_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hwltc_pkg::ST_WAIT: begin
            // [RL9] Exposure style select.
            if (accept) begin
               state_nxt = cfg_r.style_width ? hwltc_pkg::ST_WIDTH : hwltc_pkg::ST_TIMED;
            end
         end
         hwltc_pkg::ST_TIMED: begin
            // [RL12] Ignore edges while exposing.
            if (t_cnt_nxt >= timed_end) begin
               state_nxt = hwltc_pkg::ST_WAIT;
            end
         end
         hwltc_pkg::ST_WIDTH: begin
            // [RL15] No upper exposure limit.
            if (inact_edge) begin
               state_nxt = hwltc_pkg::ST_TAIL;
            end
         end
         hwltc_pkg::ST_TAIL: begin
            if (accept) begin
               state_nxt = cfg_r.style_width ? hwltc_pkg::ST_WIDTH : hwltc_pkg::ST_TIMED;
            end else if (e_cnt_nxt >= end_dly) begin
               state_nxt = hwltc_pkg::ST_WAIT;
            end
         end
         default: begin
            state_nxt = hwltc_pkg::ST_WAIT;
         end
      endcase
      if (!ext_mode) begin
         state_nxt = hwltc_pkg::ST_WAIT;
      end
   end

   // [RL11] Exposure starts after the active edge.
   assign exp_nxt = (state_nxt != hwltc_pkg::ST_WAIT) & (t_cnt_nxt >= start_dly) &
                    ((state_nxt != hwltc_pkg::ST_TAIL) | (e_cnt_nxt < end_dly));

   // [RL4] Leave waiting on acceptance.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= hwltc_pkg::ST_WAIT;
         tdiv_r <= 3'h0;
         t_cnt_r <= 24'h000000;
         e_cnt_r <= 24'h000000;
         exp_on_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tdiv_r <= tdiv_nxt;
         t_cnt_r <= t_cnt_nxt;
         e_cnt_r <= e_cnt_nxt;
         exp_on_r <= exp_nxt;
      end
   end

   // [RL7] One line per accepted trigger.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_start_r <= 1'b0;
         ovt_pulse_r <= 1'b0;
         lines_r <= 32'h00000000;
      end else begin
         line_start_r <= accept;
         ovt_pulse_r <= ovt_evt;
         lines_r <= accept ? lines_r + 32'h00000001 : lines_r;
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovt_r <= 1'b0;
         short_r <= 1'b0;
      end else begin
         ovt_r <= ovt_evt | (ovt_r & ~clr_ovt);
         short_r <= short_evt | (short_r & ~clr_short);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= hwltc_pkg::hwltc_cfg_t'(hwltc_pkg::CTRL_RST);
         exp_r <= hwltc_pkg::EXP_RST;
         ovl_r <= hwltc_pkg::OVL_RST;
         deb_r <= hwltc_pkg::DEB_RST;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            cfg_r <= hwltc_pkg::hwltc_cfg_t'(wm_ctrl[hwltc_pkg::CFG_W-1:0]);
         end
         if (hit_exp) begin
            exp_r <= wm_exp[hwltc_pkg::EXP_W-1:0];
         end
         if (hit_ovl) begin
            ovl_r <= wm_ovl[hwltc_pkg::EXP_W-1:0];
         end
         if (hit_deb) begin
            deb_r <= wm_deb[hwltc_pkg::DEB_W-1:0];
         end
      end
   end

   // [RL21] Ready status readback.
   wire [31:0] stat_word = {28'h0, short_r, ovt_r, exp_on_r, ready};
   wire [31:0] rd_mux = hit_ctrl ? {26'h0, cfg_r} :
                        hit_exp ? {15'h0, exp_r} :
                        hit_ovl ? {15'h0, ovl_r} :
                        hit_deb ? {22'h0, deb_r} :
                        hit_stat ? stat_word :
                        hit_lines ? lines_r : 32'h00000000;

   // Read data is captured in the setup cycle and held through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (setup_cyc & ~pwrite) begin
         prdata_r <= rd_mux;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign line_status.exposing = exp_on_r;
   assign line_status.ready = ready;
   assign line_status.line_start = line_start_r;
   assign line_status.overtrig = ovt_pulse_r;

   // Helper counters for timing checks.
   logic [31:0] hc_acc_r;
   logic [31:0] hc_tail_r;
   logic timed_line_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hc_acc_r <= 32'h00000000;
         hc_tail_r <= 32'h00000000;
         timed_line_r <= 1'b0;
      end else begin
         hc_acc_r <= accept ? 32'h00000000 : hc_acc_r + 32'h00000001;
         hc_tail_r <= tail_go ? 32'h00000000 : hc_tail_r + 32'h00000001;
         timed_line_r <= accept ? ~cfg_r.style_width : timed_line_r;
      end
   end

   sequence s_accept_seen;
      ready && act_edge;
   endsequence

   sequence s_line_begun;
      line_start_r && !ready_int;
   endsequence

   chk_accept_start: assert property ( // [RL3]
      @(posedge pclk) disable iff (!presetn) s_accept_seen |=> s_line_begun)
      else $error("accepted trigger did not start a line");

   chk_leave_wait: assert property ( // [RL4]
      @(posedge pclk) disable iff (!presetn)
      line_start_r |-> (state_r != hwltc_pkg::ST_WAIT) && !line_status.ready)
      else $error("waiting status kept after accepted trigger");

   chk_overtrig_drop: assert property ( // [RL6]
      @(posedge pclk) disable iff (!presetn)
      (ext_mode && act_edge && !ready_int) |=> !line_start_r && ovt_r && ovt_pulse_r)
      else $error("overtrigger not discarded and flagged");

   chk_line_count: assert property ( // [RL7]
      @(posedge pclk) disable iff (!presetn)
      line_start_r |-> lines_r == $past(lines_r) + 32'h00000001)
      else $error("line count does not follow accepted triggers");

   chk_start_delay: assert property ( // [RL22]
      @(posedge pclk) disable iff (!presetn)
      $rose(exp_on_r) && (state_r != hwltc_pkg::ST_TAIL) |->
      hc_acc_r == 32'(hwltc_pkg::TICK_CYC) * 32'(start_dly))
      else $error("exposure start delay wrong");

   chk_timed_len: assert property ( // [RL10]
      @(posedge pclk) disable iff (!presetn)
      $fell(exp_on_r) && timed_line_r && $past(ext_mode) && $stable(exp_r) && $stable(deb_r) |->
      hc_acc_r == 32'(hwltc_pkg::TICK_CYC) * 32'(timed_end))
      else $error("timed exposure length wrong");

   chk_timed_ignore: assert property ( // [RL12]
      @(posedge pclk) disable iff (!presetn)
      (state_r == hwltc_pkg::ST_TIMED && act_edge) |=> !line_start_r [*2])
      else $error("edge during timed exposure restarted it");

   chk_width_hold: assert property ( // [RL15]
      @(posedge pclk) disable iff (!presetn)
      (state_r == hwltc_pkg::ST_WIDTH && exp_on_r && !inact_edge && ext_mode) |=> exp_on_r)
      else $error("pulse width exposure ended without trigger edge");

   chk_width_end: assert property ( // [RL13]
      @(posedge pclk) disable iff (!presetn)
      $fell(exp_on_r) && ($past(state_r) == hwltc_pkg::ST_TAIL) && $past(ext_mode) |->
      hc_tail_r == 32'(hwltc_pkg::TICK_CYC) * 32'(end_dly))
      else $error("pulse width exposure end delay wrong");

   chk_overlap_ready: assert property ( // [RL16]
      @(posedge pclk) disable iff (!presetn)
      $rose(line_status.ready) && (state_r == hwltc_pkg::ST_TAIL) |->
      hc_acc_r >= 32'(hwltc_pkg::TICK_CYC) * {15'h0, ovl_r})
      else $error("ready raised before overlap limit");

   chk_status_read: assert property ( // [RL21]
      @(posedge pclk) disable iff (!presetn)
      (setup_cyc && !pwrite && hit_stat) |=> prdata[0] == $past(ready))
      else $error("ready status readback wrong");
endmodule // hwltc_top

// ===== tb/hwltc_grabber.sv
// Frame grabber model that drives trigger pulses onto the camera control lines.
`timescale 1ns/1ps
module hwltc_grabber (
   input wire logic pclk,   // System clock.
   output logic [3:0] cc_in // Camera control lines.
);
   logic idle_lvl = 1'b0;
   initial cc_in = 4'h0;
   task automatic set_idle(input logic lvl);
      @(posedge pclk);
      idle_lvl = lvl;
      cc_in <= {4{lvl}};
   endtask
   task automatic pulse(input int ln, input int w);
      @(posedge pclk);
      cc_in[ln] <= ~idle_lvl;
      repeat (w) @(posedge pclk);
      cc_in[ln] <= idle_lvl;
   endtask
endmodule // hwltc_grabber

// ===== tb/hwltc_top_test.sv
// Self-checking testbench of the external line trigger exposure controller.
`timescale 1ns/1ps
module hwltc_top_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0, cc_in;
   logic pready, pslverr, err;
   hwltc_pkg::hwltc_stat_t line_status;
   int num_errors = 0;
   int cmp_count = 0;
   int n_lines = 0;
   int deb = 0;
   int n_ovt = 0;
   logic [3:0] strb = 4'hf;
   int q_start[$];
   int q_len[$];
   int lens[2] = '{10, 200};
   int clmp[2] = '{20, 100};

   always #10 pclk = ~pclk;

   hwltc_top #(.EXP_MAX_TICKS(100)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cc_in(cc_in),
      .line_status(line_status));
   hwltc_grabber fg (.pclk(pclk), .cc_in(cc_in));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) begin
         num_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] ctrl(input logic lp, st, ed, input logic [1:0] s);
      return {26'h0, lp, st, ed, s, 1'b1};
   endfunction

   // Switching off first keeps the idle level change from being taken as an edge.
   task automatic arm(input logic [31:0] c);
      apb(1'b1, hwltc_pkg::ADDR_CTRL, c & 32'h3e);
      fg.set_idle(c[3]);
      apb(1'b1, hwltc_pkg::ADDR_CTRL, c);
   endtask

   task automatic settle;
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      while ((line_status.ready !== 1'b1 || line_status.exposing !== 1'b0) && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) begin
         num_errors++;
      end
   endtask

   task automatic line(input int ln, input int w, input int dur);
      q_start.push_back(hwltc_pkg::TICK_CYC * (hwltc_pkg::START_TICKS + deb));
      q_len.push_back(dur);
      n_lines++;
      fg.pulse(ln, w);
   endtask

   always @(posedge pclk) begin
      if (line_status.overtrig === 1'b1) begin
         n_ovt++;
      end
   end

   initial begin
      int n;
      int m;
      forever begin
         @(posedge pclk);
         if (line_status.line_start === 1'b1) begin
            n = 0;
            m = 0;
            while (line_status.exposing !== 1'b1 && n < 5000) begin
               @(posedge pclk);
               n++;
            end
            while (line_status.exposing === 1'b1 && m < 5000) begin
               @(posedge pclk);
               m++;
            end
            if (q_len.size() == 0) begin
               check("unexpected line", 32'h0, 32'h1);
            end else begin
               check("start delay", n, q_start.pop_front());
               check("exposure length", m, q_len.pop_front());
            end
         end
      end
   end

   initial begin
      #1600000;
      num_errors++;
      final_report;
   end

   initial begin
      int len;
      void'($urandom(32'hd19678a0));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, hwltc_pkg::ADDR_CTRL, 32'h0);
      check("ctrl reset", rd, {26'h0, hwltc_pkg::CTRL_RST});
      check("mapped error", err, 1'b0);
      apb(1'b0, hwltc_pkg::ADDR_EXP, 32'h0);
      check("exposure reset", rd, {15'h0, hwltc_pkg::EXP_RST});
      strb = 4'h2;
      apb(1'b1, hwltc_pkg::ADDR_EXP, 32'h00001234);
      strb = 4'hf;
      apb(1'b0, hwltc_pkg::ADDR_EXP, 32'h0);
      check("strobe lane written", rd[15:8], 8'h12);
      check("strobe lane kept", rd[7:0], hwltc_pkg::EXP_RST[7:0]);
      apb(1'b0, hwltc_pkg::ADDR_OVL, 32'h0);
      check("overlap reset", rd, {15'h0, hwltc_pkg::OVL_RST});
      apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
      check("ready when off", rd[0], 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped error", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      // Line period generation stays off while triggering.
      for (int i = 0; i < 8; i++) begin
         len = 20 + $urandom_range(80);
         apb(1'b1, hwltc_pkg::ADDR_EXP, len);
         arm(ctrl(1'b0, 1'b0, i[0], i[2:1]));
         fg.pulse((i / 2 + 1) % 4, 100);
         settle;
         line(i / 2, 100, 5 * (len - 3));
         apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
         check("status while exposing", rd[1:0], 2'b10);
         settle;
         apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
         check("status after line", rd[3:0], 4'h1);
      end
      arm(ctrl(1'b0, 1'b0, 1'b0, 2'd0));
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, hwltc_pkg::ADDR_EXP, lens[k]);
         line(0, 100, 5 * (clmp[k] - 3));
         settle;
      end
      apb(1'b1, hwltc_pkg::ADDR_EXP, 32'd100);
      line(0, 100, 485);
      repeat (50) @(posedge pclk);
      fg.pulse(0, 100);
      apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
      check("overtrigger flag", rd[2], 1'b1);
      settle;
      apb(1'b1, hwltc_pkg::ADDR_STAT, 32'h4);
      apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
      check("overtrigger cleared", rd[2], 1'b0);
      deb = 2;
      apb(1'b1, hwltc_pkg::ADDR_DEB, 32'd2);
      for (int e = 0; e < 2; e++) begin
         arm(ctrl(1'b0, 1'b1, e[0], 2'd1));
         len = 100 + $urandom_range(200);
         line(1, len, len - 15);
         settle;
      end
      // Overlap limit set below and above the pulse length.
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, hwltc_pkg::ADDR_OVL, (k == 0) ? 32'd1 : 32'd1000);
         line(1, 150, 135);
         repeat (6) @(posedge pclk);
         check("ready in tail", line_status.ready, k == 0);
         settle;
      end
      arm(ctrl(1'b1, 1'b0, 1'b0, 2'd2));
      fg.pulse(2, 100);
      repeat (20) @(posedge pclk);
      apb(1'b0, hwltc_pkg::ADDR_STAT, 32'h0);
      check("status when blocked", rd[3:0], 4'h0);
      apb(1'b0, hwltc_pkg::ADDR_LINES, 32'h0);
      check("line count", rd, n_lines);
      check("lines outstanding", q_len.size(), 32'h0);
      check("overtrigger pulses", n_ovt, 32'd1);
      final_report;
   end
endmodule // hwltc_top_test
